// >>> hdl/reset_osc_defines.svh
`ifndef RESET_OSC_DEFINES_SVH
`define RESET_OSC_DEFINES_SVH

// Oscillator control register
`define OSC_CTRL_ADDR        8'hb2
`define OSC_CTRL_RESET       8'hc0
`define OSC_EN_BIT           7
`define OSC_READY_BIT        6
`define OSC_SUSPEND_BIT      5
`define OSC_SYNC_BUSY_BIT    4
`define OSC_SPREAD_BIT       3
`define OSC_UNUSED_BIT       2
`define OSC_DIV_MSB          1
`define OSC_DIV_LSB          0
`define OSC_EN_RESET         1'b1
`define OSC_READY_RESET      1'b1
`define OSC_SPREAD_RESET     1'b0
`define OSC_DIV_RESET        2'h0
`define OSC_UNUSED_VALUE     1'b0

// Values presented on reset exit
`define PORT_LATCH_RESET     8'hff
`define PC_RESET             16'h0000

// Watchdog prescale and wake timer sync
`define WDT_DIVIDE           4'hc
`define WAKE_SYNC_CLOCKS     2'h3

`endif

// >>> hdl/reset_osc_pkg.sv
package reset_osc_pkg;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_EXIT,
        ST_RUN,
        ST_SUSPEND
    } seq_state_t;

    // Inputs from outside the clock domain, synchronised as one group
    typedef struct packed {
        logic supplyMonitor;
        logic powerOn;
        logic otherReset;
        logic oscSettled;
        logic portMatch;
        logic comparatorLow;
        logic capSenseGreater;
    } async_in_t;

    typedef struct packed {
        logic       hfOscEnable;
        logic       suspend;
        logic       spreadSpectrumEnable;
        logic [1:0] hfOscDividerSelect;
    } osc_ctrl_t;

    typedef struct packed {
        seq_state_t state;
        osc_ctrl_t  ctrl;
        logic       hfOscFreqReady;
        logic       wakeTimerSyncBusy;
        logic [1:0] syncCount;
        logic       supplyCause;
        logic [3:0] wdtCount;
        logic       wdtTick;
        logic       wdtEnable;
        logic       coreHalt;
        logic       pcClear;
        logic       stackPointerReset;
        logic       sfrPreset;
        logic       irqTimerDisable;
        logic       portPreset;
        logic       dataMemWriteBlock;
        logic       rstPinOe;
        logic       internalOscSelect;
        logic       oscRun;
        logic [7:0] sfrReadData;
    } seq_reg_t;

endpackage

// >>> hdl/reset_state_and_hf_osc_control.sv
`timescale 1ns/1ps
`include "reset_osc_defines.svh"
module reset_state_and_hf_osc_control (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Reset sources, asynchronous
    input  wire logic        supplyMonitorReset,
    input  wire logic        powerOnReset,
    input  wire logic        otherReset,
    // Oscillator analog status, asynchronous
    input  wire logic        hfOscSettled,
    // Wake sources and timer clock
    input  wire logic        portMatch,
    input  wire logic        comparatorLow,
    input  wire logic        comparatorWakeEnable,
    input  wire logic        capSenseGreater,
    input  wire logic        timer2Overflow,
    input  wire logic        timerClockTick,
    // Special function register port
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrWriteData,
    output logic      [7:0]  sfrReadData,
    // Core control
    output logic             coreHalt,
    output logic             pcClear,
    output logic      [15:0] pcResetValue,
    output logic             stackPointerReset,
    output logic             sfrPreset,
    output logic             irqTimerDisable,
    output logic             dataMemWriteBlock,
    // Ports
    output logic             portPreset,
    output logic      [7:0]  portLatchValue,
    output logic             portOpenDrain,
    output logic             weakPullupEnable,
    output logic             rstPinOut,
    output logic             rstPinOe,
    // Clocking and watchdog
    output logic             internalOscSelect,
    output logic             wdtEnable,
    output logic             wdtTick,
    // Oscillator control
    output logic             hfOscEnable,
    output logic             hfOscRun,
    output logic             spreadSpectrumEnable,
    output logic      [1:0]  hfOscDividerSelect,
    output logic             wakeTimerSyncBusy
);

    reset_osc_pkg::seq_reg_t  q;
    reset_osc_pkg::seq_reg_t  d;
    reset_osc_pkg::async_in_t rawIn;
    reset_osc_pkg::async_in_t syncIn;

    logic anyReset;
    logic otherWake;
    logic ctrlWrite;
    logic ctrlRead;

    function automatic logic [7:0] pack_ctrl(
        input reset_osc_pkg::osc_ctrl_t c,
        input logic                     ready,
        input logic                     busy
    );
        logic [7:0] v;
        v = 8'h00;
        v[`OSC_EN_BIT]                   = c.hfOscEnable;
        v[`OSC_READY_BIT]                = ready;
        v[`OSC_SUSPEND_BIT]              = c.suspend;
        v[`OSC_SYNC_BUSY_BIT]            = busy;
        v[`OSC_SPREAD_BIT]               = c.spreadSpectrumEnable;
        v[`OSC_UNUSED_BIT]               = `OSC_UNUSED_VALUE;
        v[`OSC_DIV_MSB:`OSC_DIV_LSB]     = c.hfOscDividerSelect;
        return v;
    endfunction

    always_comb begin
        rawIn.supplyMonitor   = supplyMonitorReset;
        rawIn.powerOn         = powerOnReset;
        rawIn.otherReset      = otherReset;
        rawIn.oscSettled      = hfOscSettled;
        rawIn.portMatch       = portMatch;
        rawIn.comparatorLow   = comparatorLow;
        rawIn.capSenseGreater = capSenseGreater;
    end

    // Reset sources come up asserted so nothing runs before they settle
    sync2 #(
        .W         ($bits(reset_osc_pkg::async_in_t)),
        .RESET_VAL (7'h70)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .asyncIn  (rawIn),
        .syncOut  (syncIn)
    );

    always_comb begin
        anyReset  = syncIn.supplyMonitor | syncIn.powerOn
                  | syncIn.otherReset;
        otherWake = syncIn.portMatch | syncIn.capSenseGreater
                  | (syncIn.comparatorLow & comparatorWakeEnable);
        ctrlWrite = sfrWrite && (sfrAddr == `OSC_CTRL_ADDR);
        ctrlRead  = sfrRead && (sfrAddr == `OSC_CTRL_ADDR);
    end

    always_comb begin
        d         = q;
        d.pcClear = 1'b0;
        d.wdtTick = 1'b0;

        case (q.state)
            reset_osc_pkg::ST_RESET: begin
                if (!anyReset) begin
                    d.state = reset_osc_pkg::ST_EXIT;
                end
            end
            reset_osc_pkg::ST_EXIT: begin
                d.state             = reset_osc_pkg::ST_RUN;
                d.pcClear           = 1'b1;
                d.internalOscSelect = 1'b1;
                d.wdtEnable         = 1'b1;
                d.wdtCount          = 4'h0;
                d.supplyCause       = 1'b0;
            end
            reset_osc_pkg::ST_RUN: begin
                if (ctrlWrite) begin
                    d.ctrl.hfOscEnable =
                        sfrWriteData[`OSC_EN_BIT];
                    d.ctrl.spreadSpectrumEnable =
                        sfrWriteData[`OSC_SPREAD_BIT];
                    d.ctrl.hfOscDividerSelect =
                        sfrWriteData[`OSC_DIV_MSB:`OSC_DIV_LSB];
                    // Divider to one is the caller's duty, not checked here
                    if (sfrWriteData[`OSC_SUSPEND_BIT]) begin
                        d.ctrl.suspend = 1'b1;
                        d.state        = reset_osc_pkg::ST_SUSPEND;
                    end
                end
            end
            reset_osc_pkg::ST_SUSPEND: begin
                // Port match is a level, so a standing match wakes at once
                if (timer2Overflow || otherWake) begin
                    d.ctrl.suspend = 1'b0;
                    d.state        = reset_osc_pkg::ST_RUN;
                    d.syncCount    = 2'h0;
                    if (!timer2Overflow) begin
                        d.wakeTimerSyncBusy = 1'b1;
                    end
                end
            end
            default: begin
                d.state = reset_osc_pkg::ST_RESET;
            end
        endcase

        // Timer access held off for three timer clocks after other wakes
        // Only counts in RUN, so a fresh wake's set is never undone here
        if (q.wakeTimerSyncBusy && timerClockTick
                && q.state == reset_osc_pkg::ST_RUN) begin
            if (q.syncCount == `WAKE_SYNC_CLOCKS - 2'h1) begin
                d.wakeTimerSyncBusy = 1'b0;
            end
            d.syncCount = q.syncCount + 2'h1;
        end

        // Watchdog prescale counts only while code runs
        if (q.wdtEnable && q.state == reset_osc_pkg::ST_RUN) begin
            if (q.wdtCount == `WDT_DIVIDE - 4'h1) begin
                d.wdtCount = 4'h0;
                d.wdtTick  = 1'b1;
            end else begin
                d.wdtCount = q.wdtCount + 4'h1;
            end
        end

        // Reset wins over everything but a due wdtTick, which still fires, from any state
        if (anyReset) begin
            d.state                     = reset_osc_pkg::ST_RESET;
            d.ctrl.hfOscEnable          = `OSC_EN_RESET;
            d.ctrl.suspend              = 1'b0;
            d.ctrl.spreadSpectrumEnable = `OSC_SPREAD_RESET;
            d.ctrl.hfOscDividerSelect   = `OSC_DIV_RESET;
            d.wakeTimerSyncBusy         = 1'b0;
            d.syncCount                 = 2'h0;
            d.wdtEnable                 = 1'b0;
            d.wdtCount                  = 4'h0;
            d.pcClear                   = 1'b0;
            if (syncIn.supplyMonitor || syncIn.powerOn) begin
                d.supplyCause = 1'b1;
            end
        end

        // Ready flag follows the oscillator; not writable
        d.oscRun = d.ctrl.hfOscEnable && !d.ctrl.suspend;
        if (anyReset) begin
            d.hfOscFreqReady = `OSC_READY_RESET;
        end else begin
            d.hfOscFreqReady = d.oscRun && syncIn.oscSettled;
        end

        // Status outputs follow the state being entered
        d.coreHalt          = (d.state != reset_osc_pkg::ST_RUN);
        d.sfrPreset         = (d.state == reset_osc_pkg::ST_RESET);
        d.irqTimerDisable   = (d.state == reset_osc_pkg::ST_RESET);
        d.stackPointerReset = (d.state == reset_osc_pkg::ST_RESET);
        d.portPreset        = (d.state == reset_osc_pkg::ST_RESET);
        // Memory is never cleared; writes are only blocked in the RESET state
        d.dataMemWriteBlock = (d.state == reset_osc_pkg::ST_RESET);
        d.rstPinOe          = (d.state == reset_osc_pkg::ST_RESET)
                            && d.supplyCause;

        if (ctrlRead) begin
            d.sfrReadData = pack_ctrl(q.ctrl, q.hfOscFreqReady,
                                      q.wakeTimerSyncBusy);
        end else begin
            d.sfrReadData = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q.state                     <= reset_osc_pkg::ST_RESET;
            q.ctrl.hfOscEnable          <= `OSC_EN_RESET;
            q.ctrl.suspend              <= 1'b0;
            q.ctrl.spreadSpectrumEnable <= `OSC_SPREAD_RESET;
            q.ctrl.hfOscDividerSelect   <= `OSC_DIV_RESET;
            q.hfOscFreqReady            <= `OSC_READY_RESET;
            q.wakeTimerSyncBusy         <= 1'b0;
            q.syncCount                 <= 2'h0;
            q.supplyCause               <= 1'b1;
            q.wdtCount                  <= 4'h0;
            q.wdtTick                   <= 1'b0;
            q.wdtEnable                 <= 1'b0;
            q.coreHalt                  <= 1'b1;
            q.pcClear                   <= 1'b0;
            q.stackPointerReset         <= 1'b1;
            q.sfrPreset                 <= 1'b1;
            q.irqTimerDisable           <= 1'b1;
            q.portPreset                <= 1'b1;
            q.dataMemWriteBlock         <= 1'b1;
            q.rstPinOe                  <= 1'b1;
            q.internalOscSelect         <= 1'b1;
            q.oscRun                    <= 1'b1;
            q.sfrReadData               <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // Constant-valued outputs still come from flops
    logic [7:0]  portLatch_q;
    logic [15:0] pcValue_q;
    logic        pullup_q;
    logic        rstPinLow_q;

    always_ff @(posedge core_clk) begin
        portLatch_q <= `PORT_LATCH_RESET;
        pcValue_q   <= `PC_RESET;
        pullup_q    <= 1'b1;
        rstPinLow_q <= 1'b0;
    end

    assign sfrReadData          = q.sfrReadData;
    assign coreHalt             = q.coreHalt;
    assign pcClear              = q.pcClear;
    assign pcResetValue         = pcValue_q;
    assign stackPointerReset    = q.stackPointerReset;
    assign sfrPreset            = q.sfrPreset;
    assign irqTimerDisable      = q.irqTimerDisable;
    assign dataMemWriteBlock    = q.dataMemWriteBlock;
    assign portPreset           = q.portPreset;
    assign portLatchValue       = portLatch_q;
    assign portOpenDrain        = q.portPreset;
    assign weakPullupEnable     = pullup_q;
    assign rstPinOut            = rstPinLow_q;
    assign rstPinOe             = q.rstPinOe;
    assign internalOscSelect    = q.internalOscSelect;
    assign wdtEnable            = q.wdtEnable;
    assign wdtTick              = q.wdtTick;
    assign hfOscEnable          = q.ctrl.hfOscEnable;
    assign hfOscRun             = q.oscRun;
    assign spreadSpectrumEnable = q.ctrl.spreadSpectrumEnable;
    assign hfOscDividerSelect   = q.ctrl.hfOscDividerSelect;
    assign wakeTimerSyncBusy    = q.wakeTimerSyncBusy;

endmodule // reset_state_and_hf_osc_control

// >>> hdl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int                W         = 1,
    parameter logic [W-1:0]      RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // Data
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    logic [2*W-1:0] stage_q;
    logic [2*W-1:0] stage_d;

    // First stage feeds only the second
    always_comb begin
        stage_d = {stage_q[W-1:0], asyncIn};
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage_q <= {RESET_VAL, RESET_VAL};
        end else begin
            stage_q <= stage_d;
        end
    end

    assign syncOut = stage_q[2*W-1:W];

endmodule // sync2

// >>> verification/osc_model.sv
`timescale 1ns/1ps
module osc_model (
    // Clock
    input  wire logic core_clk,
    // Oscillator run request
    input  wire logic hfOscRun,
    // Analog status and timer clock
    output logic      hfOscSettled = 1'b0,
    output logic      timerClockTick = 1'b0
);
    logic [1:0] runDly_q = 2'h0;
    logic [1:0] tickCnt_q = 2'h0;
    // Settling lags the run request, so ready cannot echo the enable
    always @(posedge core_clk) begin
        runDly_q <= {runDly_q[0], hfOscRun};
        hfOscSettled <= runDly_q[1];
        tickCnt_q <= tickCnt_q + 2'h1;
        timerClockTick <= (tickCnt_q == 2'h3);
    end
endmodule // osc_model

// >>> verification/reset_osc_assertions.sv
`timescale 1ns/1ps
module reset_osc_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // Inputs
    input wire logic        otherReset,
    input wire logic [7:0]  sfrAddr,
    input wire logic        sfrWrite,
    input wire logic        sfrRead,
    input wire logic [7:0]  sfrWriteData,
    // Outputs
    input wire logic [7:0]  sfrReadData,
    input wire logic        coreHalt,
    input wire logic        pcClear,
    input wire logic [15:0] pcResetValue,
    input wire logic        sfrPreset,
    input wire logic        portPreset,
    input wire logic [7:0]  portLatchValue,
    input wire logic        portOpenDrain,
    input wire logic        weakPullupEnable,
    input wire logic        rstPinOut,
    input wire logic        rstPinOe,
    input wire logic        internalOscSelect,
    input wire logic        wdtEnable,
    input wire logic        wdtTick,
    input wire logic        hfOscEnable,
    input wire logic        hfOscRun,
    input wire logic        spreadSpectrumEnable,
    input wire logic [1:0]  hfOscDividerSelect,
    input wire logic        wakeTimerSyncBusy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Reset itself is the cause here, so no disable
    rst_halt_a: assert property (disable iff (1'b0)
        srst |=> coreHalt && sfrPreset) else $error("halt missing");
    port_preset_a: assert property (disable iff (1'b0)
        srst |=> portPreset && portOpenDrain && portLatchValue == 8'hff)
        else $error("port preset wrong");
    pullup_on_a: assert property (weakPullupEnable)
        else $error("pull-up off");
    rst_pin_a: assert property (rstPinOe |-> coreHalt && !rstPinOut)
        else $error("reset pin driven outside reset");
    exit_seq_a: assert property (pcClear |-> pcResetValue == 16'h0000
        && internalOscSelect ##1 !coreHalt && wdtEnable)
        else $error("exit sequence wrong");
    wdt_gap_a: assert property (wdtTick |=> !wdtTick [*8])
        else $error("watchdog tick too early");
    unused_zero_a: assert property (!sfrReadData[2])
        else $error("unused bit set");
    read_fields_a: assert property (sfrRead && sfrAddr == 8'hb2
        && !sfrWrite |=> sfrReadData[7] == hfOscEnable
        && sfrReadData[3] == spreadSpectrumEnable
        && sfrReadData[1:0] == hfOscDividerSelect)
        else $error("read fields wrong");
    write_take_a: assert property (sfrWrite && sfrAddr == 8'hb2
        && !coreHalt |=> hfOscEnable == $past(sfrWriteData[7])
        && spreadSpectrumEnable == $past(sfrWriteData[3])
        && hfOscDividerSelect == $past(sfrWriteData[1:0]))
        else $error("write not taken");
    suspend_entry_a: assert property (sfrWrite && sfrAddr == 8'hb2
        && sfrWriteData[5] && !coreHalt |=> coreHalt && !hfOscRun)
        else $error("suspend not entered");
    busy_bound_a: assert property ($rose(wakeTimerSyncBusy)
        |-> !coreHalt ##[1:20] !wakeTimerSyncBusy)
        else $error("sync busy stuck");
    hold_reset_a: assert property (otherReset [*4]
        |-> coreHalt && sfrPreset) else $error("reset not held");
    c_susp: cover property (sfrWrite && sfrWriteData[5] && !coreHalt);
    c_busy: cover property ($rose(wakeTimerSyncBusy));
    c_exit: cover property (pcClear);
    c_wdt: cover property (wdtTick);
endmodule // reset_osc_checker
bind reset_state_and_hf_osc_control reset_osc_checker u_chk (.*);

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       core_clk = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] rstSrc = 3'h0;
    logic [3:0] wake = 4'h0;
    logic       comparatorWakeEnable = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic       sfrWrite = 1'b0;
    logic       sfrRead = 1'b0;
    logic [7:0] sfrWriteData = 8'h00;
    logic       hfOscSettled;
    logic       timerClockTick;
    logic [7:0] sfrReadData, portLatchValue;
    logic [15:0] pcResetValue;
    logic [1:0] hfOscDividerSelect;
    logic       coreHalt, pcClear, stackPointerReset, sfrPreset;
    logic       irqTimerDisable, dataMemWriteBlock, portPreset;
    logic       portOpenDrain, weakPullupEnable, rstPinOut, rstPinOe;
    logic       internalOscSelect, wdtEnable, wdtTick, hfOscEnable;
    logic       hfOscRun, spreadSpectrumEnable, wakeTimerSyncBusy;
    int         n_mismatch = 0;
    int         checks = 0;
    int         n;

    always #2.5 core_clk = ~core_clk;

    reset_state_and_hf_osc_control uut (
        .otherReset        (rstSrc[0]),
        .powerOnReset      (rstSrc[1]),
        .supplyMonitorReset(rstSrc[2]),
        .timer2Overflow    (wake[0]),
        .portMatch         (wake[1]),
        .comparatorLow     (wake[2]),
        .capSenseGreater   (wake[3]),
        .*
    );
    osc_model partner (
        .core_clk      (core_clk),
        .hfOscRun      (hfOscRun),
        .hfOscSettled  (hfOscSettled),
        .timerClockTick(timerClockTick)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrWriteData <= v;
        sfrWrite <= 1'b1;
        @(posedge core_clk);
        sfrWrite <= 1'b0;
    endtask

    // Read data is registered at the taking edge and stands for that one cycle only; checked 1 ns after it
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge core_clk);
        sfrRead <= 1'b0;
        #1 check(sfrReadData, exp);
    endtask

    task automatic wait_run();
        for (n = 0; n < 60 && coreHalt !== 1'b0; n++) @(negedge core_clk);
    endtask

    task automatic pulse(input int w);
        @(posedge core_clk);
        wake[w] <= 1'b1;
        @(posedge core_clk);
        wake[w] <= 1'b0;
    endtask

    task automatic suspend_wake(input int w);
        sfr_wr(8'hb2, 8'ha3);
        @(negedge core_clk);
        check(coreHalt, 1'b1);
        check(hfOscRun, 1'b0);
        sfr_wr(8'hb2, 8'h80);
        if (w == 2) begin
            pulse(w);
            repeat (6) @(posedge core_clk);
            check(coreHalt, 1'b1);
            comparatorWakeEnable <= 1'b1;
        end
        pulse(w);
        wait_run();
        check(coreHalt, 1'b0);
        check(hfOscRun, 1'b1);
        check(hfOscDividerSelect, 2'h3);
        check(wakeTimerSyncBusy, w != 0);
        n = 0;
        for (int g = 0; g < 40 && wakeTimerSyncBusy === 1'b1; g++) begin
            if (timerClockTick === 1'b1)
                n++;
            @(negedge core_clk);
        end
        check(16'(n), (w != 0) ? 16'h3 : 16'h0);
    endtask

    // Power-on and supply causes drive the pin, the other does not
    task automatic rst_src(input int s);
        @(posedge core_clk);
        rstSrc[s] <= 1'b1;
        repeat (10) @(posedge core_clk);
        check(coreHalt, 1'b1);
        check(rstPinOe, s != 0);
        check(stackPointerReset, 1'b1);
        check(dataMemWriteBlock, 1'b1);
        check(weakPullupEnable, 1'b1);
        rstSrc[s] <= 1'b0;
        for (n = 0; n < 20 && pcClear !== 1'b1; n++) @(negedge core_clk);
        check(pcClear, 1'b1);
        check(pcResetValue, 16'h0000);
        @(negedge core_clk);
        check(coreHalt, 1'b0);
        check(wdtEnable, 1'b1);
        check(internalOscSelect, 1'b1);
        sfr_rd(8'hb2, 8'hc0);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        check(coreHalt, 1'b1);
        check(sfrPreset, 1'b1);
        check(irqTimerDisable, 1'b1);
        check(portLatchValue, 8'hff);
        check(portOpenDrain, 1'b1);
        srst <= 1'b0;
        wait_run();
        sfr_rd(8'hb2, 8'hc0);
        sfr_wr(8'hb3, 8'h0b);
        sfr_rd(8'hb3, 8'h00);
        check(spreadSpectrumEnable, 1'b0);
        sfr_wr(8'hb2, 8'hdf);
        sfr_rd(8'hb2, 8'hcb);
        for (int i = 0; i < 4; i++) begin
            sfr_wr(8'hb2, 8'h80 | 8'(i));
            sfr_rd(8'hb2, 8'hc0 | 8'(i));
            check(hfOscDividerSelect, 16'(i));
        end
        sfr_wr(8'hb2, 8'h00);
        repeat (10) @(posedge core_clk);
        sfr_rd(8'hb2, 8'h00);
        sfr_wr(8'hb2, 8'h80);
        repeat (10) @(posedge core_clk);
        sfr_rd(8'hb2, 8'hc0);
        for (n = 0; n < 30 && wdtTick !== 1'b1; n++) @(negedge core_clk);
        @(negedge core_clk);
        for (n = 1; n < 30 && wdtTick !== 1'b1; n++) @(negedge core_clk);
        check(16'(n), 16'hc);
        for (int w = 0; w < 4; w++)
            suspend_wake(w);
        for (int s = 0; s < 3; s++) begin
            sfr_wr(8'hb2, (s == 1) ? 8'ha3 : 8'h8b);
            rst_src(s);
        end
        print_verdict();
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        #50us;
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_top
